//--- rtl/fe_op_ctrl.v
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
`include "fe_op_map.vh"

module fe_op_ctrl #(
   parameter PAGE_AW   = 5,
   parameter PE_CYCLES = `FE_PE_TIME_US * `FE_CLK_MHZ
) (
   input  wire        clk,
   input  wire        srst,
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg         hreadyout,
   output reg         hresp,
   output reg  [31:0] hrdata,
   input  wire        progEnter,
   output reg         progModeActive,
   output reg  [23:0] memAddr,
   output reg         memWe,
   output reg         memRe,
   output reg         memErase,
   output reg         memBulkFlash,
   output reg         memBulkData,
   output reg  [7:0]  memWdata,
   input  wire [7:0]  memRdata,
   output reg         irq
);

   // --------------------------------------------------------
   // states
   // --------------------------------------------------------
   localparam [2:0] S_IDLE = 3'h0;
   localparam [2:0] S_CLR  = 3'h1;
   localparam [2:0] S_PRD  = 3'h2;
   localparam [2:0] S_PWR  = 3'h3;
   localparam [2:0] S_ERS  = 3'h4;
   localparam [2:0] S_WAIT = 3'h5;
   localparam [2:0] S_VRD  = 3'h6;
   localparam [2:0] S_VCMP = 3'h7;

   localparam [19:0]        PE_CNT   = PE_CYCLES[19:0];
   localparam [19:0]        BULK_CNT = {PE_CYCLES[18:0], 1'b0};
   localparam [PAGE_AW-1:0] IDX_LAST = {PAGE_AW{1'b1}};

   // --------------------------------------------------------
   // storage
   // --------------------------------------------------------
   reg  [7:0]         mode_q;
   reg  [7:0]         ctrl_q;
   reg                done_q;
   reg                vGood_q;
   reg  [1:0]         irqSt_q;
   reg  [1:0]         irqMsk_q;
   reg  [23:0]        addr_q;
   reg  [23:0]        csum_q;
   reg  [2:0]         state_q;
   reg  [PAGE_AW-1:0] idx_q;
   reg  [PAGE_AW-1:0] bufPtr_q;
   reg  [19:0]        cnt_q;
   reg                bulk_q;
   reg                vFail_q;
   reg                aWr_q;
   reg  [7:0]         aIdx_q;
   reg                crst_q;
   reg                clrReq_q;

   wire [7:0]         bufRd;
   wire [7:0]         wIdx;
   wire [7:0]         wd;
   wire               wr;
   wire               addrPh;
   wire               ctrlWr;
   wire               modeOk;
   wire               startPe;
   wire               startVfy;
   wire               finish;
   wire               bufWe;
   wire [PAGE_AW-1:0] bufWa;
   wire [7:0]         bufWd;
   wire [23:0]        pageAddr;
   wire [7:0]         expByte;

   // --------------------------------------------------------
   // helpers
   // --------------------------------------------------------
   function [7:0] pickByte;
      input [23:0] v;
      input [1:0]  sel;
      begin
         case (sel)
            2'h0:    pickByte = v[7:0];
            2'h1:    pickByte = v[15:8];
            2'h2:    pickByte = v[23:16];
            default: pickByte = 8'h00;
         endcase
      end
   endfunction

   // --------------------------------------------------------
   // bus decode
   // --------------------------------------------------------
   assign addrPh = hsel & htrans[1] & hready & (haddr[31:10] == 22'h000000);
   assign wr     = aWr_q;
   assign wIdx   = aIdx_q;
   assign wd     = hwdata[7:0];
   assign ctrlWr = wr & (wIdx == `FE_IDX_CTRL);

   assign modeOk   = progModeActive & mode_q[`FE_M_EN] &
                     (mode_q[`FE_M_PGM] | mode_q[`FE_M_ERASE]) & (state_q == S_IDLE) & ~crst_q;
   assign startPe  = ctrlWr & wd[`FE_C_START] & modeOk & ~mode_q[`FE_M_VFY];
   assign startVfy = ctrlWr & wd[`FE_C_VERIFY] & modeOk & mode_q[`FE_M_VFY];
   assign finish   = ((state_q == S_WAIT) & ((bulk_q ? BULK_CNT : PE_CNT) == cnt_q)) |
                     ((state_q == S_VCMP) & (idx_q == IDX_LAST));

   assign pageAddr = {addr_q[23:PAGE_AW], {PAGE_AW{1'b0}}};
   assign expByte  = mode_q[`FE_M_ERASE] ? 8'hFF : bufRd;

   assign bufWe = (state_q == S_CLR) |
                  (wr & (wIdx == `FE_IDX_DATA) & mode_q[`FE_M_PBSEL] & (state_q == S_IDLE));
   assign bufWa = (state_q == S_CLR) ? idx_q : bufPtr_q;
   assign bufWd = (state_q == S_CLR) ? 8'h00 : wd;

   fe_page_buf #(
      .AW (PAGE_AW),
      .DW (8)
   ) u_buf (
      .clk      (clk),
      .wrEn     (bufWe),
      .wrAddr   (bufWa),
      .wrData   (bufWd),
      .rdAddr   (idx_q),
      .rdData_q (bufRd)
   );

   // --------------------------------------------------------
   // bus slave
   // --------------------------------------------------------
   always @(posedge clk) begin
      if (srst) begin
         aWr_q     <= 1'b0;
         aIdx_q    <= 8'h00;
         hrdata    <= 32'h00000000;
         hreadyout <= 1'b0;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         aWr_q     <= addrPh & hwrite;
         aIdx_q    <= haddr[9:2];
         if (addrPh & ~hwrite) begin
            case (haddr[9:2])
               `FE_IDX_MODE:   hrdata <= {24'h000000, mode_q};
               `FE_IDX_CTRL:   hrdata <= {24'h000000, ctrl_q};
               `FE_IDX_STAT:   hrdata <= {24'h000000, done_q, vGood_q, 2'b00, irqSt_q[`FE_I_DONE],
                                          mode_q[`FE_M_PGM] & ~mode_q[`FE_M_VFY],
                                          mode_q[`FE_M_ERASE] & ~mode_q[`FE_M_VFY], mode_q[`FE_M_VFY]};
               `FE_IDX_ADRL:   hrdata <= {24'h000000, pickByte(csum_q, 2'h0)};
               `FE_IDX_ADRM:   hrdata <= {24'h000000, pickByte(csum_q, 2'h1)};
               `FE_IDX_ADRH:   hrdata <= {24'h000000, pickByte(csum_q, 2'h2)};
               `FE_IDX_IRQST:  hrdata <= {30'h0000000, irqSt_q};
               `FE_IDX_IRQMSK: hrdata <= {30'h0000000, irqMsk_q};
               default:        hrdata <= 32'h00000000;
            endcase
         end
      end
   end

   // --------------------------------------------------------
   // software registers
   // --------------------------------------------------------
   always @(posedge clk) begin
      if (srst) begin
         mode_q         <= `FE_MODE_RST;
         ctrl_q         <= `FE_CTRL_RST;
         irqMsk_q       <= 2'b00;
         progModeActive <= 1'b0;
         crst_q         <= 1'b0;
         clrReq_q       <= 1'b0;
      end else begin
         ctrl_q[`FE_C_START]  <= 1'b0;
         ctrl_q[`FE_C_VERIFY] <= 1'b0;
         ctrl_q[`FE_C_EXIT1]  <= 1'b0;
         ctrl_q[`FE_C_EXIT0]  <= 1'b0;
         ctrl_q[`FE_C_CRST]   <= 1'b1;
         ctrl_q[`FE_C_PBRST]  <= 1'b1;
         crst_q               <= 1'b0;
         clrReq_q             <= 1'b0;
         if (progEnter) begin
            progModeActive <= 1'b1;
         end
         if (wr & (wIdx == `FE_IDX_MODE)) begin
            mode_q <= wd;
         end
         if (wr & (wIdx == `FE_IDX_IRQMSK)) begin
            irqMsk_q <= wd[1:0];
         end
         if (ctrlWr) begin
            ctrl_q <= wd;
            if (wd[`FE_C_EXIT1] & wd[`FE_C_EXIT0]) begin
               progModeActive <= 1'b0;
            end
            crst_q <= wd[`FE_C_CRST];
            clrReq_q <= ~wd[`FE_C_PBRST] & ~mode_q[`FE_M_PBSEL];
         end
      end
   end

   // --------------------------------------------------------
   // operation sequencer
   // --------------------------------------------------------
   always @(posedge clk) begin
      if (srst) begin
         state_q      <= S_IDLE;
         idx_q        <= {PAGE_AW{1'b0}};
         bufPtr_q     <= {PAGE_AW{1'b0}};
         cnt_q        <= 20'h00000;
         bulk_q       <= 1'b0;
         vFail_q      <= 1'b0;
         done_q       <= 1'b1;
         vGood_q      <= 1'b0;
         addr_q       <= 24'h000000;
         csum_q       <= 24'h000000;
         memAddr      <= 24'h000000;
         memWe        <= 1'b0;
         memRe        <= 1'b0;
         memErase     <= 1'b0;
         memBulkFlash <= 1'b0;
         memBulkData  <= 1'b0;
         memWdata     <= 8'h00;
      end else begin
         memWe    <= 1'b0;
         memRe    <= 1'b0;
         memErase <= 1'b0;
         if (wr & (wIdx == `FE_IDX_ADRL)) addr_q[7:0]   <= wd;
         if (wr & (wIdx == `FE_IDX_ADRM)) addr_q[15:8]  <= wd;
         if (wr & (wIdx == `FE_IDX_ADRH)) addr_q[23:16] <= wd;
         if (wr & (wIdx == `FE_IDX_STAT)) vGood_q <= wd[`FE_S_VGOOD];
         if (bufWe & (state_q == S_IDLE)) bufPtr_q <= bufPtr_q + 1'b1;
         if (ctrlWr & ~wd[`FE_C_PBRST] & mode_q[`FE_M_PBSEL]) begin
            csum_q <= 24'h000000;
         end
         case (state_q)
            S_IDLE: begin
               idx_q <= {PAGE_AW{1'b0}};
               cnt_q <= 20'h00000;
               if (clrReq_q) begin
                  bufPtr_q <= {PAGE_AW{1'b0}};
                  state_q  <= S_CLR;
               end else if (startPe) begin
                  done_q <= 1'b0;
                  bulk_q <= wd[`FE_C_BULKF] | wd[`FE_C_BULKD];
                  state_q <= mode_q[`FE_M_ERASE] ? S_ERS : S_PRD;
               end else if (startVfy) begin
                  done_q  <= 1'b0;
                  vFail_q <= 1'b0;
                  state_q <= S_VRD;
               end
            end
            S_CLR: begin
               idx_q <= idx_q + 1'b1;
               if (idx_q == IDX_LAST) state_q <= S_IDLE;
            end
            S_PRD: begin
               state_q <= S_PWR;
            end
            S_PWR: begin
               memAddr  <= pageAddr | {{(24-PAGE_AW){1'b0}}, idx_q};
               memWdata <= bufRd;
               memWe    <= 1'b1;
               idx_q    <= idx_q + 1'b1;
               state_q  <= (idx_q == IDX_LAST) ? S_WAIT : S_PRD;
            end
            S_ERS: begin
               memAddr      <= pageAddr;
               memErase     <= 1'b1;
               memBulkFlash <= bulk_q & ctrl_q[`FE_C_BULKF];
               memBulkData  <= bulk_q & ctrl_q[`FE_C_BULKD];
               state_q      <= S_WAIT;
            end
            S_WAIT: begin
               cnt_q <= cnt_q + 1'b1;
               if (finish) begin
                  done_q       <= 1'b1;
                  memBulkFlash <= 1'b0;
                  memBulkData  <= 1'b0;
                  state_q      <= S_IDLE;
               end
            end
            S_VRD: begin
               memAddr <= addr_q;
               memRe   <= 1'b1;
               state_q <= S_VCMP;
            end
            S_VCMP: begin
               if (~memRe) begin
                  csum_q <= csum_q + {16'h0000, memRdata};
                  if (memRdata != expByte) vFail_q <= 1'b1;
                  addr_q <= addr_q + 24'h000001;
                  idx_q  <= idx_q + 1'b1;
                  if (finish) begin
                     vGood_q <= ~vFail_q & (memRdata == expByte);
                     done_q  <= 1'b1;
                     state_q <= S_IDLE;
                  end else begin
                     state_q <= S_VRD;
                  end
               end
            end
            default: state_q <= S_IDLE;
         endcase
         if (crst_q) begin
            state_q      <= S_IDLE;
            done_q       <= 1'b1;
            memBulkFlash <= 1'b0;
            memBulkData  <= 1'b0;
            memWe        <= 1'b0;
            memRe        <= 1'b0;
            memErase     <= 1'b0;
         end
      end
   end

   // --------------------------------------------------------
   // interrupt status
   // --------------------------------------------------------
   always @(posedge clk) begin
      if (srst) begin
         irqSt_q <= 2'b00;
         irq     <= 1'b0;
      end else begin
         if (wr & (wIdx == `FE_IDX_IRQST)) begin
            irqSt_q <= irqSt_q & ~wd[1:0];
         end
         if (finish & ~crst_q & ~((state_q == S_VCMP) & memRe)) begin
            irqSt_q[`FE_I_DONE] <= 1'b1;
            if ((state_q == S_VCMP) & (vFail_q | (memRdata != expByte))) begin
               irqSt_q[`FE_I_VFAIL] <= 1'b1;
            end
         end
         irq <= |(irqSt_q & irqMsk_q);
      end
   end

endmodule
`default_nettype wire

//--- rtl/fe_op_map.vh
// Contract
// - start-program/erase and start-verify act only in program, erase or verify mode, targeting the indirect address.
// - every cell or page-buffer access uses the strobes made by this controller.
// - the indirect address drives the cells only during program, erase and verify operations.
// - the operation-done flag reads 0 while an operation runs and 1 once it has completed.
// - the start-verify bit self-clears one clock after a 1 is written.
// - writing 1 to the controller-reset bit resets the control logic and the bit returns after one clock; 0 does nothing.
// - the interrupt request flag reads 1 while pending and is raised when an operation completes.
// - the operation-done flag clears when an operation begins and sets when it ends.
// - verify advances the address by one per location; program and erase ignore the page-offset bits.
// - the address registers are write-only and read back the 24-bit checksum.
`ifndef FE_OP_MAP_VH
`define FE_OP_MAP_VH

// --------------------------------------------------------
// register indices, byte address is index times four
// --------------------------------------------------------
`define FE_IDX_MODE   8'hEA
`define FE_IDX_CTRL   8'hEB
`define FE_IDX_STAT   8'hEC
`define FE_IDX_ADRL   8'hF2
`define FE_IDX_ADRM   8'hF3
`define FE_IDX_ADRH   8'hF4
`define FE_IDX_DATA   8'hF5
`define FE_IDX_IRQST  8'hF8
`define FE_IDX_IRQMSK 8'hF9

// --------------------------------------------------------
// reset values
// --------------------------------------------------------
`define FE_MODE_RST   8'h00
`define FE_CTRL_RST   8'h03
`define FE_STAT_RST   8'h80

// --------------------------------------------------------
// mode register bits
// --------------------------------------------------------
`define FE_M_PGM      5
`define FE_M_ERASE    4
`define FE_M_PBSEL    3
`define FE_M_VFY      1
`define FE_M_EN       0

// --------------------------------------------------------
// control register bits
// --------------------------------------------------------
`define FE_C_BULKF    7
`define FE_C_BULKD    6
`define FE_C_EXIT1    5
`define FE_C_EXIT0    4
`define FE_C_START    3
`define FE_C_VERIFY   2
`define FE_C_CRST     1
`define FE_C_PBRST    0

// --------------------------------------------------------
// status register bits and interrupt bits
// --------------------------------------------------------
`define FE_S_DONE     7
`define FE_S_VGOOD    6
`define FE_S_IRQ      3
`define FE_S_WRITE_MODE_FLAG    2
`define FE_S_ERASE_MODE_FLAG    1
`define FE_S_VERIFY_MODE_FLAG    0
`define FE_I_DONE     0
`define FE_I_VFAIL    1

// --------------------------------------------------------
// timing
// --------------------------------------------------------
`define FE_CLK_MHZ    50
`define FE_PE_TIME_US 2500

`endif

//--- rtl/fe_page_buf.v
`timescale 1ns/10ps
`default_nettype none

module fe_page_buf #(
   parameter AW = 5,
   parameter DW = 8
) (
   input  wire          clk,
   input  wire          wrEn,
   input  wire [AW-1:0] wrAddr,
   input  wire [DW-1:0] wrData,
   input  wire [AW-1:0] rdAddr,
   output reg  [DW-1:0] rdData_q
);

   reg [DW-1:0] mem [0:(1<<AW)-1];

   // --------------------------------------------------------
   // write port and registered read port
   // --------------------------------------------------------
   always @(posedge clk) begin
      if (wrEn) begin
         mem[wrAddr] <= wrData;
      end
      rdData_q <= mem[rdAddr];
   end

endmodule
`default_nettype wire

//--- testbench/fe_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
module fe_mem_model (
   input  wire logic        clk,
   input  wire logic [23:0] memAddr,
   input  wire logic        memWe,
   input  wire logic        memRe,
   input  wire logic        memErase,
   input  wire logic [7:0]  memWdata,
   input  wire logic        badRead,
   output var  logic [7:0]  memRdata
);
   logic [7:0] cells [0:8191];
   logic       reVld = 1'b0;
   logic [7:0] lastQ = 8'h00;
   initial begin
      for (int i = 0; i < 8192; i++) begin
         cells[i] = 8'h00;
      end
   end
   // ----
   // cell array
   // ----
   // strobed cell access
   always @(posedge clk) begin
      reVld <= memRe;
      if (memRe) begin
         lastQ <= cells[memAddr[12:0]] ^ {8{badRead}};
      end
      if (memWe) begin
         cells[memAddr[12:0]] <= memWdata;
      end
      if (memErase) begin
         for (int i = 0; i < 32; i++) begin
            cells[{memAddr[12:5], i[4:0]}] <= 8'hFF;
         end
      end
   end
   // stale data shown inverted
   assign memRdata = reVld ? lastQ : ~lastQ;
endmodule
`default_nettype wire

//--- testbench/fe_op_ctrl_checker.sv
`timescale 1ns/10ps
`default_nettype none
`include "fe_op_map.vh"
module fe_op_ctrl_checker (
   input wire logic        clk,
   input wire logic        srst,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic        progModeActive,
   input wire logic [23:0] memAddr,
   input wire logic        memWe,
   input wire logic        memRe,
   input wire logic        memErase
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   // ----
   // sequences
   // ----
   sequence ctrlWrAddr;
      hsel && htrans[1] && hready && hwrite && haddr == {22'h0, `FE_IDX_CTRL, 2'h0};
   endsequence
   sequence exitWr;
      ctrlWrAddr ##1 (hwdata[5:4] == 2'h3);
   endsequence
   sequence stayWr;
      ctrlWrAddr ##1 (hwdata[5:4] != 2'h3 && !hwdata[1] && progModeActive);
   endsequence
   chk_exit_leaves: assert property (exitWr |=> !progModeActive)
      else $error("exit code did not leave program mode");
   chk_exit_stays: assert property (stayWr |=> progModeActive)
      else $error("program mode left on other exit code");
   chk_strobe_mode: assert property ((memWe || memRe || memErase) |-> progModeActive)
      else $error("cell strobe outside program mode");
   chk_we_pulse: assert property (memWe |=> !memWe)
      else $error("write strobe longer than one cycle");
   chk_re_pulse: assert property (memRe |=> !memRe [*2])
      else $error("verify reads closer than three cycles");
   chk_erase_page: assert property (memErase |-> memAddr[4:0] == 5'h00)
      else $error("erase address not page aligned");
   chk_verify_step: assert property (memRe ##3 memRe |-> memAddr == $past(memAddr, 3) + 24'h1)
      else $error("verify address did not advance by one");
   chk_write_step: assert property (memWe ##2 memWe |-> memAddr == $past(memAddr, 2) + 24'h1)
      else $error("program address did not advance by one");
endmodule
bind fe_op_ctrl fe_op_ctrl_checker u_chk (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .progModeActive(progModeActive),
   .memAddr(memAddr), .memWe(memWe), .memRe(memRe), .memErase(memErase));
`default_nettype wire

//--- testbench/fe_op_ctrl_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "fe_op_map.vh"
module fe_op_ctrl_tb;
   logic        clk = 1'b0, srst = 1'b1, hsel = 1'b0, hwrite = 1'b0, progEnter = 1'b0, badRead = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic [1:0]  htrans = 2'h0;
   logic        hready, hreadyout, hresp, progModeActive, memWe, memRe, memErase, irq, bulkF, bulkD;
   logic [23:0] memAddr, sum;
   logic [7:0]  memWdata, memRdata, rd;
   int          mismatches = 0, compares = 0, cycles = 0;
   assign hready = hreadyout;
   always #10 clk = ~clk;
   fe_op_ctrl #(.PAGE_AW(5), .PE_CYCLES(20)) dut (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .progEnter(progEnter),
      .progModeActive(progModeActive), .memAddr(memAddr), .memWe(memWe), .memRe(memRe),
      .memErase(memErase), .memBulkFlash(bulkF), .memBulkData(bulkD), .memWdata(memWdata), .memRdata(memRdata),
      .irq(irq));
   fe_mem_model mem (.clk(clk), .memAddr(memAddr), .memWe(memWe), .memRe(memRe), .memErase(memErase),
      .memWdata(memWdata), .badRead(badRead), .memRdata(memRdata));
   // ----
   // bus tasks
   // ----
   task automatic bus(input logic wrt, input logic [7:0] idx, input logic [7:0] wd);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wrt;
      haddr <= {22'h0, idx, 2'h0};
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, wd};
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      rd = hrdata[7:0];
   endtask
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic rdchk(input string nm, input logic [7:0] idx, input logic [7:0] msk, input logic [7:0] exp);
      bus(1'b0, idx, 8'h00);
      chk(nm, exp, rd & msk);
      chk("hresp", 8'h00, {7'h0, hresp});
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
      bus(1'b1, idx, wd);
   endtask
   task automatic setAddr(input logic [7:0] lo);
      wr(`FE_IDX_ADRL, lo);
      wr(`FE_IDX_ADRM, 8'h00);
      wr(`FE_IDX_ADRH, 8'h00);
   endtask
   task automatic waitDone();
      int n;
      n = 0;
      rd = 8'h00;
      while (rd[7] !== 1'b1 && n < 400) begin
         bus(1'b0, `FE_IDX_STAT, 8'h00);
         n++;
      end
      chk("done", 8'h80, rd & 8'h80);
   endtask
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         print_verdict();
      end
   end
   // ----
   // tests
   // ----
   initial begin
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      rdchk("mode", `FE_IDX_MODE, 8'hFF, 8'h00);
      rdchk("ctrl", `FE_IDX_CTRL, 8'hFF, 8'h03);
      rdchk("stat", `FE_IDX_STAT, 8'hFF, 8'h80);
      rdchk("unmapped", 8'h00, 8'hFF, 8'h00);
      wr(`FE_IDX_MODE, 8'h21);
      wr(`FE_IDX_CTRL, 8'h09);
      rdchk("noStart", `FE_IDX_STAT, 8'h80, 8'h80);
      $display("test reset finished");
      progEnter <= 1'b1;
      @(posedge clk);
      progEnter <= 1'b0;
      wr(`FE_IDX_MODE, 8'h01);
      wr(`FE_IDX_CTRL, 8'h00);
      repeat (40) @(posedge clk);
      wr(`FE_IDX_MODE, 8'h09);
      for (int i = 0; i < 32; i++) wr(`FE_IDX_DATA, 8'h10 + i[7:0]);
      wr(`FE_IDX_MODE, 8'h21);
      setAddr(8'h40);
      wr(`FE_IDX_CTRL, 8'h09);
      rdchk("busy", `FE_IDX_STAT, 8'h80, 8'h00);
      waitDone();
      rdchk("irqSt", `FE_IDX_IRQST, 8'h03, 8'h01);
      rdchk("stIrq", `FE_IDX_STAT, 8'h08, 8'h08);
      for (int i = 0; i < 32; i++) chk("cell", 8'h10 + i[7:0], mem.cells[8'h40 + i]);
      $display("test program finished");
      wr(`FE_IDX_MODE, 8'h09);
      wr(`FE_IDX_CTRL, 8'h00);
      wr(`FE_IDX_MODE, 8'h23);
      setAddr(8'h40);
      wr(`FE_IDX_CTRL, 8'h05);
      rdchk("vfyBit", `FE_IDX_CTRL, 8'h04, 8'h00);
      waitDone();
      rdchk("vGood", `FE_IDX_STAT, 8'h40, 8'h40);
      sum = 24'h0;
      for (int i = 0; i < 32; i++) sum += 24'h10 + i[23:0];
      rdchk("sumL", `FE_IDX_ADRL, 8'hFF, sum[7:0]);
      rdchk("sumM", `FE_IDX_ADRM, 8'hFF, sum[15:8]);
      rdchk("sumH", `FE_IDX_ADRH, 8'hFF, sum[23:16]);
      badRead <= 1'b1;
      setAddr(8'h40);
      wr(`FE_IDX_CTRL, 8'h05);
      waitDone();
      badRead <= 1'b0;
      rdchk("vBad", `FE_IDX_STAT, 8'h40, 8'h00);
      rdchk("irqSt2", `FE_IDX_IRQST, 8'h03, 8'h03);
      wr(`FE_IDX_MODE, 8'h09);
      wr(`FE_IDX_CTRL, 8'h00);
      rdchk("sumClrL", `FE_IDX_ADRL, 8'hFF, 8'h00);
      rdchk("sumClrM", `FE_IDX_ADRM, 8'hFF, 8'h00);
      $display("test verify finished");
      chk("irqMasked", 8'h00, {7'h0, irq});
      wr(`FE_IDX_IRQMSK, 8'h01);
      repeat (2) @(posedge clk);
      chk("irqOn", 8'h01, {7'h0, irq});
      wr(`FE_IDX_IRQST, 8'h01);
      repeat (2) @(posedge clk);
      chk("irqOff", 8'h00, {7'h0, irq});
      rdchk("irqSt3", `FE_IDX_IRQST, 8'h03, 8'h02);
      $display("test interrupt finished");
      wr(`FE_IDX_MODE, 8'h11);
      setAddr(8'h45);
      wr(`FE_IDX_CTRL, 8'h09);
      waitDone();
      for (int i = 0; i < 32; i++) chk("erased", 8'hFF, mem.cells[8'h40 + i]);
      $display("test erase finished");
      wr(`FE_IDX_CTRL, 8'h89);
      rdchk("bulkBusy", `FE_IDX_STAT, 8'h80, 8'h00);
      chk("bulkF", 8'h01, {7'h0, bulkF});
      chk("bulkD", 8'h00, {7'h0, bulkD});
      waitDone();
      chk("bulkEnd", 8'h00, {7'h0, bulkF});
      wr(`FE_IDX_MODE, 8'h01);
      wr(`FE_IDX_CTRL, 8'h00);
      repeat (40) @(posedge clk);
      wr(`FE_IDX_MODE, 8'h21);
      wr(`FE_IDX_CTRL, 8'h09);
      waitDone();
      for (int i = 0; i < 32; i++) chk("cleared", 8'h00, mem.cells[8'h40 + i]);
      $display("test bulk finished");
      wr(`FE_IDX_MODE, 8'h21);
      wr(`FE_IDX_CTRL, 8'h09);
      wr(`FE_IDX_CTRL, 8'h03);
      rdchk("abort", `FE_IDX_STAT, 8'h80, 8'h80);
      rdchk("crstBit", `FE_IDX_CTRL, 8'h03, 8'h03);
      wr(`FE_IDX_CTRL, 8'h11);
      wr(`FE_IDX_CTRL, 8'h21);
      chk("stay", 8'h01, {7'h0, progModeActive});
      wr(`FE_IDX_CTRL, 8'h31);
      @(posedge clk);
      chk("left", 8'h00, {7'h0, progModeActive});
      rdchk("exitBits", `FE_IDX_CTRL, 8'h30, 8'h00);
      $display("test exit finished");
      print_verdict();
   end
endmodule
`default_nettype wire
